/* src/pmii_pkg.sv */
`default_nettype none

package pmii_pkg;

   // Reference and link rates; the divider counts are derived from them.
   localparam int PMII_SYS_HZ = 50_000_000;
   localparam int PMII_LINK100_HZ = 25_000_000;
   localparam int PMII_LINK10_HZ = 2_500_000;
   localparam int PMII_MDC_HZ = 2_500_000;
   localparam logic [3:0] PMII_HALF100 =
      4'(PMII_SYS_HZ / (2 * PMII_LINK100_HZ));
   localparam logic [3:0] PMII_HALF10 =
      4'(PMII_SYS_HZ / (2 * PMII_LINK10_HZ));
   localparam logic [3:0] PMII_MDC_HALF =
      4'(PMII_SYS_HZ / (2 * PMII_MDC_HZ));

   // Management frame layout in bits; PMII_TA_FIRST, PMII_DATA_FIRST and PMII_FRAME_LAST count from the first preamble bit.
   localparam logic [5:0] PMII_PRE_BITS = 6'h20;
   localparam logic [4:0] PMII_HDR_LAST = 5'h0C;
   localparam logic [4:0] PMII_TA_LAST = 5'h01;
   localparam logic [4:0] PMII_DATA_LAST = 5'h0F;
   localparam logic [4:0] PMII_DATA_BITS = 5'h10;
   localparam logic [5:0] PMII_FRAME_LAST = 6'h3F;
   localparam logic [5:0] PMII_TA_FIRST = 6'h2E;
   localparam logic [5:0] PMII_DATA_FIRST = 6'h30;
   localparam logic [31:0] PMII_PREAMBLE = 32'hFFFF_FFFF;
   localparam logic [1:0] PMII_START = 2'h1;
   localparam logic [1:0] PMII_OP_READ = 2'h2;
   localparam logic [1:0] PMII_OP_WRITE = 2'h1;
   localparam logic [1:0] PMII_TA_WRITE = 2'h2;

   typedef enum logic [1:0] {
      PMII_MG_PRE,
      PMII_MG_HDR,
      PMII_MG_TA,
      PMII_MG_DATA
   } pmii_mg_t;

   typedef enum logic {
      PMII_MM_IDLE,
      PMII_MM_RUN
   } pmii_mm_t;

   typedef struct packed {
      logic [3:0] div;
      logic txc;
      logic rxc;
      logic txen_s1;
      logic txen_s2;
      logic txen_prev;
      logic [3:0] txd_s1;
      logic [3:0] txd_s2;
      logic mdc_s1;
      logic mdc_s2;
      logic mdc_prev;
      logic mdio_s1;
      logic mdio_s2;
      logic [3:0] tx_nib;
      logic tx_valid;
      logic tx_end;
      logic [3:0] rxd;
      logic rxdv;
      logic rxer;
      logic rx_take;
      logic col;
      logic crs;
      pmii_mg_t mst;
      logic [5:0] pre_cnt;
      logic [4:0] bcnt;
      logic [12:0] hdr;
      logic [15:0] sh;
      logic rd;
      logic mdio_o;
      logic mdio_oe_n;
      logic [4:0] maddr;
      logic [15:0] mwdata;
      logic mwr;
   } pmii_phy_st_t;

   typedef struct packed {
      logic txc_s1;
      logic txc_s2;
      logic txc_prev;
      logic rxc_s1;
      logic rxc_s2;
      logic rxc_prev;
      logic [3:0] rxd_s1;
      logic [3:0] rxd_s2;
      logic rxdv_s1;
      logic rxdv_s2;
      logic rxer_s1;
      logic rxer_s2;
      logic col_s1;
      logic col_s2;
      logic crs_s1;
      logic crs_s2;
      logic mdio_s1;
      logic mdio_s2;
      logic txen;
      logic [3:0] txd;
      logic tx_take;
      logic [3:0] rx_nib;
      logic rx_valid;
      logic rx_err;
      logic rx_frame;
      pmii_mm_t mst;
      logic [3:0] mdiv;
      logic mdc;
      logic [5:0] bit_n;
      logic [63:0] frame;
      logic rd;
      logic [15:0] rdata;
      logic mdio_o;
      logic mdio_oe_n;
      logic busy;
      logic done;
   } pmii_mac_st_t;

   localparam pmii_phy_st_t PMII_PHY_RST = '{
      mdio_oe_n: 1'h1, mst: PMII_MG_PRE, default: '0};
   localparam pmii_mac_st_t PMII_MAC_RST = '{
      mdio_oe_n: 1'h1, mst: PMII_MM_IDLE, default: '0};

endpackage

`default_nettype wire

/* src/pmii_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface pmii_if;
   logic txc;
   logic txen;
   logic [3:0] txd;
   logic rxc;
   logic rxdv;
   logic [3:0] rxd;
   logic rxer;
   logic col;
   logic crs;
   logic mdc;
   logic phy_mdio_o;
   logic phy_mdio_oe_n;
   logic mac_mdio_o;
   logic mac_mdio_oe_n;
   logic mdio;

   // The shared line idles high, as a pull-up would hold it.
   assign mdio = !phy_mdio_oe_n ? phy_mdio_o :
                 !mac_mdio_oe_n ? mac_mdio_o : 1'h1;

   modport phy (
      output txc, rxc, rxdv, rxd, rxer, col, crs,
      output phy_mdio_o, phy_mdio_oe_n,
      input txen, txd, mdc, mdio
   );

   modport mac (
      input txc, rxc, rxdv, rxd, rxer, col, crs, mdio,
      output txen, txd, mdc, mac_mdio_o, mac_mdio_oe_n
   );
endinterface

`default_nettype wire

/* src/pmii_mac.sv */
`timescale 1ns/1ps
`default_nettype none

module pmii_mac (
   input wire logic sys_clk,
   input wire logic reset_n,
   pmii_if.mac link,
   input wire logic [3:0] tx_nib,
   input wire logic tx_valid,
   output logic tx_take,
   output logic [3:0] rx_nib,
   output logic rx_valid,
   output logic rx_err,
   output logic rx_frame,
   output logic col,
   output logic crs,
   input wire logic mgmt_start,
   input wire logic mgmt_read,
   input wire logic [4:0] mgmt_phy,
   input wire logic [4:0] mgmt_reg,
   input wire logic [15:0] mgmt_wdata,
   output logic [15:0] mgmt_rdata,
   output logic mgmt_busy,
   output logic mgmt_done
);
   import pmii_pkg::*;

   // Both link clocks are found by the same sampled-edge test.
   function automatic logic rising(input logic now_v, input logic was_v);
      return now_v && !was_v;
   endfunction

   pmii_mac_st_t q;
   pmii_mac_st_t d;

   always_comb begin
      d = q;
      d.tx_take = 1'h0;
      d.rx_valid = 1'h0;
      d.done = 1'h0;
      d.txc_s1 = link.txc;
      d.txc_s2 = q.txc_s1;
      d.txc_prev = q.txc_s2;
      d.rxc_s1 = link.rxc;
      d.rxc_s2 = q.rxc_s1;
      d.rxc_prev = q.rxc_s2;
      d.rxd_s1 = link.rxd;
      d.rxd_s2 = q.rxd_s1;
      d.rxdv_s1 = link.rxdv;
      d.rxdv_s2 = q.rxdv_s1;
      d.rxer_s1 = link.rxer;
      d.rxer_s2 = q.rxer_s1;
      d.col_s1 = link.col;
      d.col_s2 = q.col_s1;
      d.crs_s1 = link.crs;
      d.crs_s2 = q.crs_s1;
      d.mdio_s1 = link.mdio;
      d.mdio_s2 = q.mdio_s1;
      // Drive the next nibble on each transmit clock rise.
      if (rising(q.txc_s2, q.txc_prev)) begin // [RULE3]
         d.txen = tx_valid;
         d.txd = tx_valid ? tx_nib : 4'h0;
         d.tx_take = tx_valid;
      end
      // Data valid and data are taken on the receive clock rise.
      if (rising(q.rxc_s2, q.rxc_prev)) begin // [RULE8]
         d.rx_valid = q.rxdv_s2;
         d.rx_frame = q.rxdv_s2;
         d.rx_nib = q.rxd_s2;
         d.rx_err = q.rxer_s2;
      end
      case (q.mst)
         PMII_MM_IDLE: begin
            d.mdc = 1'h0;
            if (mgmt_start) begin
               // Clause-22 frame, most significant bit first.
               d.frame = {PMII_PREAMBLE, PMII_START, // [RULE14]
                  mgmt_read ? PMII_OP_READ : PMII_OP_WRITE,
                  mgmt_phy, mgmt_reg, PMII_TA_WRITE,
                  mgmt_read ? 16'h0000 : mgmt_wdata};
               d.mdio_o = 1'h1;
               d.mdio_oe_n = 1'h0;
               d.rd = mgmt_read;
               d.bit_n = 6'h00;
               d.mdiv = 4'h0;
               d.busy = 1'h1;
               d.mst = PMII_MM_RUN;
            end
         end
         PMII_MM_RUN: begin
            // The management clock is made here, unrelated to the link.
            if (q.mdiv >= PMII_MDC_HALF - 4'h1) begin // [RULE11]
               d.mdiv = 4'h0;
               d.mdc = !q.mdc;
               if (!q.mdc) begin
                  if (q.rd && q.bit_n >= PMII_DATA_FIRST) begin
                     d.rdata = {q.rdata[14:0], q.mdio_s2};
                  end
               end else if (q.bit_n == PMII_FRAME_LAST) begin
                  d.mdio_oe_n = 1'h1;
                  d.busy = 1'h0;
                  d.done = 1'h1;
                  d.mst = PMII_MM_IDLE;
               end else begin
                  d.bit_n = 6'(q.bit_n + 6'h01);
                  d.frame = {q.frame[62:0], 1'h0};
                  d.mdio_o = q.frame[62];
                  // A read hands the line over at turnaround.
                  d.mdio_oe_n = q.rd && // [RULE12]
                     (d.bit_n >= PMII_TA_FIRST);
               end
            end else begin
               d.mdiv = 4'(q.mdiv + 4'h1);
            end
         end
         default: d.mst = PMII_MM_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      q <= reset_n ? d : PMII_MAC_RST;
   end

   assign link.txen = q.txen;
   assign link.txd = q.txd;
   assign link.mdc = q.mdc;
   assign link.mac_mdio_o = q.mdio_o;
   assign link.mac_mdio_oe_n = q.mdio_oe_n;
   assign tx_take = q.tx_take;
   assign rx_nib = q.rx_nib;
   assign rx_valid = q.rx_valid;
   assign rx_err = q.rx_err;
   assign rx_frame = q.rx_frame;
   assign col = q.col_s2;
   assign crs = q.crs_s2;
   assign mgmt_rdata = q.rdata;
   assign mgmt_busy = q.busy;
   assign mgmt_done = q.done;
endmodule

`default_nettype wire

/* src/pmii_phy.sv */
// How it works
// RULE1: Device drives free-running transmit clock.
// RULE2: Transmit data accepted only while enable high.
// RULE3: MAC drives data synchronous to transmit clock.
// RULE4: Receive clock 25 MHz or 2.5 MHz.
// RULE5: Collision output high during medium collision.
// RULE6: Carrier sense high whenever medium busy.
// RULE7: Data valid high during packet, drops after.
// RULE8: Data valid stable at receive clock rise.
// RULE9: Receive nibbles driven aligned to receive clock.
// RULE10: Receive error high on any decode fault; here rxer rises only while rx_valid is high.
// RULE11: Management clock may be fully asynchronous.
// RULE12: Management data line shared, released when idle.
// RULE13: All link timing from one reference.
// RULE14: Management frames follow clause-22 format.
// RULE15: Enable drop ends frame after last nibble.
`timescale 1ns/1ps
`default_nettype none

module pmii_phy (
   input wire logic sys_clk,
   input wire logic reset_n,
   pmii_if.phy link,
   input wire logic speed_100,
   output logic [3:0] tx_nib,
   output logic tx_valid,
   output logic tx_end,
   input wire logic [3:0] rx_nib,
   input wire logic rx_valid,
   input wire logic rx_err,
   output logic rx_take,
   input wire logic col_det,
   input wire logic crs_det,
   input wire logic [4:0] phy_addr,
   output logic [4:0] mgmt_addr,
   output logic [15:0] mgmt_wdata,
   output logic mgmt_wr,
   input wire logic [15:0] mgmt_rdata
);
   import pmii_pkg::*;

   // The header, turnaround and data bit counters of the management parser step the same way.
   function automatic logic [4:0] count_up(input logic [4:0] c);
      return 5'(c + 5'h01);
   endfunction

   pmii_phy_st_t q;
   pmii_phy_st_t d;

   always_comb begin
      logic [3:0] half;
      logic tick;
      logic rise;
      logic fall;
      logic mrise;
      logic [12:0] hdr_n;
      logic [15:0] sh_n;
      half = speed_100 ? PMII_HALF100 : PMII_HALF10;
      tick = q.div >= half - 4'h1;
      rise = tick && !q.txc;
      fall = tick && q.txc;
      mrise = q.mdc_s2 && !q.mdc_prev;
      hdr_n = {q.hdr[11:0], q.mdio_s2};
      sh_n = {q.sh[14:0], q.mdio_s2};
      d = q;
      d.tx_valid = 1'h0;
      d.tx_end = 1'h0;
      d.rx_take = 1'h0;
      d.mwr = 1'h0;

      // One divider from the reference clocks both directions.
      if (tick) begin // [RULE13]
         d.div = 4'h0;
         d.txc = !q.txc; // [RULE1]
         d.rxc = !q.rxc; // [RULE4]
      end else begin
         d.div = 4'(q.div + 4'h1);
      end

      d.txen_s1 = link.txen;
      d.txen_s2 = q.txen_s1;
      d.txd_s1 = link.txd;
      d.txd_s2 = q.txd_s1;
      d.mdc_s1 = link.mdc;
      d.mdc_s2 = q.mdc_s1;
      d.mdc_prev = q.mdc_s2;
      d.mdio_s1 = link.mdio;
      d.mdio_s2 = q.mdio_s1;

      // Pins pass two flip-flops, so the sample lags the clock by a fixed
      // amount; one sample per period still sees each nibble exactly once.
      if (rise) begin
         d.txen_prev = q.txen_s2;
         if (q.txen_s2) begin
            d.tx_nib = q.txd_s2; // [RULE2]
            d.tx_valid = 1'h1;
         end
         d.tx_end = q.txen_prev && !q.txen_s2; // [RULE15]
      end

      // Receive outputs change on the falling edge so that they are
      // settled at the rising edge where the MAC samples them.
      if (fall) begin
         d.rxdv = rx_valid; // [RULE7] [RULE8]
         d.rxd = rx_valid ? rx_nib : 4'h0; // [RULE9]
         d.rxer = rx_valid && rx_err; // [RULE10]
         d.rx_take = rx_valid;
      end

      d.col = col_det; // [RULE5]
      d.crs = crs_det; // [RULE6]

      // The management clock is only sampled, never used as a clock,
      // so its rate and phase need no relation to the link.
      case (q.mst) // [RULE11]
         PMII_MG_PRE: begin
            if (mrise) begin
               if (q.mdio_s2) begin
                  if (q.pre_cnt < PMII_PRE_BITS) begin
                     d.pre_cnt = 6'(q.pre_cnt + 6'h01);
                  end
               end else if (q.pre_cnt >= PMII_PRE_BITS) begin
                  d.pre_cnt = 6'h00;
                  d.bcnt = 5'h00;
                  d.mst = PMII_MG_HDR; // [RULE14]
               end else begin
                  d.pre_cnt = 6'h00;
               end
            end
         end
         PMII_MG_HDR: begin
            if (mrise) begin
               d.hdr = hdr_n;
               d.bcnt = count_up(q.bcnt);
               if (q.bcnt == PMII_HDR_LAST) begin
                  d.bcnt = 5'h00;
                  d.mst = PMII_MG_PRE;
                  // Start, opcode and address must all match.
                  if (hdr_n[12] && hdr_n[9:5] == phy_addr && // [RULE14]
                      (hdr_n[11:10] == PMII_OP_READ ||
                       hdr_n[11:10] == PMII_OP_WRITE)) begin
                     d.rd = hdr_n[11:10] == PMII_OP_READ;
                     d.maddr = hdr_n[4:0];
                     d.mst = PMII_MG_TA;
                  end
               end
            end
         end
         PMII_MG_TA: begin
            if (mrise) begin
               if (q.rd) begin
                  // First turnaround bit left floating, second driven low.
                  d.mdio_o = 1'h0;
                  d.mdio_oe_n = 1'h0; // [RULE12]
                  d.sh = mgmt_rdata;
                  d.bcnt = 5'h00;
                  d.mst = PMII_MG_DATA;
               end else if (q.bcnt == PMII_TA_LAST) begin
                  d.bcnt = 5'h00;
                  d.mst = PMII_MG_DATA;
               end else begin
                  d.bcnt = count_up(q.bcnt);
               end
            end
         end
         PMII_MG_DATA: begin
            if (mrise) begin
               if (q.rd) begin
                  if (q.bcnt == PMII_DATA_BITS) begin
                     d.mdio_oe_n = 1'h1; // [RULE12]
                     d.mst = PMII_MG_PRE;
                  end else begin
                     d.mdio_o = q.sh[15];
                     d.sh = {q.sh[14:0], 1'h0};
                     d.bcnt = count_up(q.bcnt);
                  end
               end else begin
                  d.sh = sh_n;
                  if (q.bcnt == PMII_DATA_LAST) begin
                     d.mwdata = sh_n;
                     d.mwr = 1'h1;
                     d.mst = PMII_MG_PRE;
                  end else begin
                     d.bcnt = count_up(q.bcnt);
                  end
               end
            end
         end
         default: begin
            d.mdio_oe_n = 1'h1;
            d.mst = PMII_MG_PRE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      q <= reset_n ? d : PMII_PHY_RST;
   end

   assign link.txc = q.txc;
   assign link.rxc = q.rxc;
   assign link.rxdv = q.rxdv;
   assign link.rxd = q.rxd;
   assign link.rxer = q.rxer;
   assign link.col = q.col;
   assign link.crs = q.crs;
   assign link.phy_mdio_o = q.mdio_o;
   assign link.phy_mdio_oe_n = q.mdio_oe_n;
   assign tx_nib = q.tx_nib;
   assign tx_valid = q.tx_valid;
   assign tx_end = q.tx_end;
   assign rx_take = q.rx_take;
   assign mgmt_addr = q.maddr;
   assign mgmt_wdata = q.mwdata;
   assign mgmt_wr = q.mwr;
endmodule

`default_nettype wire

/* tb/pmii_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module pmii_checker (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic txc,
   input wire logic rxc,
   input wire logic rxdv,
   input wire logic [3:0] rxd,
   input wire logic rxer,
   input wire logic mdc,
   input wire logic phy_mdio_oe_n,
   input wire logic mac_mdio_o,
   input wire logic mac_mdio_oe_n
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   clocks_aligned_a: assert property (rxc == txc)
      else $error("receive clock left the transmit clock");
   txc_runs_a: assert property ($rose(txc) |-> ##[1:20] $rose(txc))
      else $error("transmit clock stopped");
   rx_idle_zero_a: assert property (!rxdv |-> rxd == 4'h0 && !rxer)
      else $error("receive lines busy outside a frame");
   rx_stable_rise_a: assert property ($rose(rxc) |->
      $stable(rxdv) && $stable(rxd) && $stable(rxer))
      else $error("receive lines moved at a clock rise");
   mdc_high_hold_a: assert property ($rose(mdc) |=> mdc [*8])
      else $error("management clock high phase too short");
   mdc_low_hold_a: assert property ($fell(mdc) |=> !mdc [*8])
      else $error("management clock low phase too short");
   mdio_fall_edge_a: assert property (!mac_mdio_oe_n &&
      !$past(mac_mdio_oe_n) && $changed(mac_mdio_o) |-> $fell(mdc))
      else $error("management data moved away from a clock fall");
   mdio_no_clash_a: assert property (
      phy_mdio_oe_n || mac_mdio_oe_n)
      else $error("both ends drive the management line");
endmodule

`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
   $display("wrong value at %0t got %h expected %h", $time, (g), (e)); end end
`define WAITFOR(c, b) begin n = 0; while ((c) !== 1'h1 && n < (b)) begin \
   @(posedge sys_clk); n++; end if ((c) !== 1'h1) begin fails++; \
   tally_and_finish(); end end

module tb;
   logic sys_clk = 1'h0;
   logic reset_n = 1'h0;
   logic speed_100 = 1'h1;
   logic [3:0] m_tx_nib = 4'h0, m_rx_nib, p_tx_nib, p_rx_nib = 4'h0;
   logic m_tx_valid = 1'h0, m_tx_take, m_rx_valid, m_rx_err, m_rx_frame;
   logic m_col, m_crs, m_start = 1'h0, m_read = 1'h0, m_busy, m_done;
   logic [4:0] m_phy = 5'h0, m_reg = 5'h0, p_maddr, v;
   logic [15:0] m_wdata = 16'h0, m_rdata, p_mwdata, p_mrdata = 16'h0;
   logic p_tx_valid, p_tx_end, p_rx_valid = 1'h0, p_rx_err = 1'h0;
   logic p_rx_take, p_col = 1'h0, p_crs = 1'h0, p_mwr;
   logic [20:0] e;
   logic [3:0] tx_q[$];
   logic [4:0] rx_q[$];
   logic [20:0] wr_q[$];
   int compares = 0, fails = 0, n, i, k;

   always #10 sys_clk = ~sys_clk;

   pmii_if link();

   pmii_mac u_pmii_mac (.sys_clk(sys_clk), .reset_n(reset_n), .link(link),
      .tx_nib(m_tx_nib), .tx_valid(m_tx_valid), .tx_take(m_tx_take),
      .rx_nib(m_rx_nib), .rx_valid(m_rx_valid), .rx_err(m_rx_err),
      .rx_frame(m_rx_frame), .col(m_col), .crs(m_crs), .mgmt_start(m_start),
      .mgmt_read(m_read), .mgmt_phy(m_phy), .mgmt_reg(m_reg),
      .mgmt_wdata(m_wdata), .mgmt_rdata(m_rdata), .mgmt_busy(m_busy),
      .mgmt_done(m_done));

   // The management address is tied; a second address is only ever sent.
   pmii_phy u_pmii_phy (.sys_clk(sys_clk), .reset_n(reset_n), .link(link),
      .speed_100(speed_100), .tx_nib(p_tx_nib), .tx_valid(p_tx_valid),
      .tx_end(p_tx_end), .rx_nib(p_rx_nib), .rx_valid(p_rx_valid),
      .rx_err(p_rx_err), .rx_take(p_rx_take), .col_det(p_col),
      .crs_det(p_crs), .phy_addr(5'h05), .mgmt_addr(p_maddr),
      .mgmt_wdata(p_mwdata), .mgmt_wr(p_mwr), .mgmt_rdata(p_mrdata));

   pmii_checker u_pmii_checker (.sys_clk(sys_clk), .reset_n(reset_n),
      .txc(link.txc), .rxc(link.rxc), .rxdv(link.rxdv), .rxd(link.rxd),
      .rxer(link.rxer), .mdc(link.mdc), .phy_mdio_oe_n(link.phy_mdio_oe_n),
      .mac_mdio_o(link.mac_mdio_o), .mac_mdio_oe_n(link.mac_mdio_oe_n));

   // An empty queue at a pulse means a unit nobody sent, so it is a fault.
   always @(posedge sys_clk) begin
      if (p_tx_valid === 1'h1) begin
         `CHK(tx_q.size() != 0, 1'h1)
         if (tx_q.size() != 0) begin
            e = 21'(tx_q.pop_front());
            `CHK(p_tx_nib, e[3:0])
         end
      end
      if (m_rx_valid === 1'h1) begin
         `CHK(rx_q.size() != 0, 1'h1)
         if (rx_q.size() != 0) begin
            e = 21'(rx_q.pop_front());
            `CHK({m_rx_err, m_rx_nib}, e[4:0])
         end
      end
      if (p_mwr === 1'h1) begin
         `CHK(wr_q.size() != 0, 1'h1)
         if (wr_q.size() != 0) begin
            e = wr_q.pop_front();
            `CHK({p_maddr, p_mwdata}, e)
         end
      end
   end

   task automatic tally_and_finish();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic send_tx(input int cnt);
      for (i = 0; i < cnt; i++) begin
         v = 5'($urandom);
         m_tx_nib <= v[3:0];
         m_tx_valid <= 1'h1;
         tx_q.push_back(v[3:0]);
         @(posedge sys_clk);
         `WAITFOR(m_tx_take, 60)
      end
      m_tx_valid <= 1'h0;
      `WAITFOR(p_tx_end, 80)
      `CHK(tx_q.size(), 0)
   endtask

   task automatic send_rx(input int cnt);
      for (i = 0; i < cnt; i++) begin
         v = 5'($urandom);
         p_rx_nib <= v[3:0];
         p_rx_err <= v[4];
         p_rx_valid <= 1'h1;
         rx_q.push_back(v);
         @(posedge sys_clk);
         `WAITFOR(p_rx_take, 60)
      end
      p_rx_valid <= 1'h0;
      @(posedge sys_clk);
      `WAITFOR(!m_rx_frame, 80)
      `CHK(rx_q.size(), 0)
   endtask

   // Rise-to-rise distance of the receive clock, counted in system cycles.
   task automatic measure(input int exp);
      `WAITFOR(!link.rxc, 40)
      `WAITFOR(link.rxc, 40)
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (link.rxc !== 1'h0 && k < 40);
      do begin
         @(posedge sys_clk);
         k++;
      end while (link.rxc !== 1'h1 && k < 40);
      `CHK(k, exp)
      // A clock that never came back has already been counted above.
      if (k >= 40) begin
         tally_and_finish();
      end
   endtask

   task automatic mgmt(input logic rd, input logic [4:0] phy,
                       input logic [15:0] wd, input logic [15:0] exp);
      `WAITFOR(!m_busy, 4)
      v = 5'($urandom);
      m_reg <= v;
      m_read <= rd;
      m_phy <= phy;
      m_wdata <= wd;
      p_mrdata <= wd;
      m_start <= 1'h1;
      if (!rd && phy == 5'h05) wr_q.push_back({v, wd});
      @(posedge sys_clk);
      m_start <= 1'h0;
      `WAITFOR(m_done, 1500)
      if (rd) `CHK(m_rdata, exp)
   endtask

   initial begin
      void'($urandom(27603));
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'h1;
      @(posedge sys_clk);
      send_tx(12);
      send_rx(12);
      for (int j = 0; j < 4; j++) begin
         v = 5'($urandom);
         p_col <= v[0];
         p_crs <= v[1];
         repeat (4) @(posedge sys_clk);
         `CHK(m_col, v[0])
         `CHK(m_crs, v[1])
      end
      measure(2);
      mgmt(1'h0, 5'h05, 16'hA5C3, 16'h0);
      mgmt(1'h1, 5'h05, 16'h3C5A, 16'h3C5A);
      mgmt(1'h0, 5'h06, 16'h1234, 16'h0);
      mgmt(1'h1, 5'h06, 16'h1234, 16'hFFFF);
      mgmt(1'h0, 5'h05, 16'h5AA5, 16'h0);
      repeat (4) @(posedge sys_clk);
      `CHK(wr_q.size(), 0)
      speed_100 <= 1'h0;
      repeat (40) @(posedge sys_clk);
      measure(20);
      send_tx(4);
      send_rx(4);
      tally_and_finish();
   end
endmodule

`default_nettype wire
